// file: rtl/wso_pkg.sv
`default_nettype none

package wso_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  OPT_REG_INDEX  = 8'h1F;
   localparam logic [7:0]  STAT_REG_INDEX = 8'h20;
   localparam logic [31:0] OPT_REG_ADDR   = {22'h0, OPT_REG_INDEX, 2'h0};
   localparam logic [31:0] STAT_REG_ADDR  = {22'h0, STAT_REG_INDEX, 2'h0};

   // Option byte field positions
   localparam int unsigned OPT_WDOG_OFF_BIT  = 0;
   localparam int unsigned OPT_STOP_EN_BIT   = 1;
   localparam int unsigned OPT_WDOG_LONG_BIT = 2;
   localparam int unsigned OPT_SHORT_WK_BIT  = 3;
   localparam int unsigned OPT_LVI_RSTB_BIT  = 4;
   localparam int unsigned OPT_LVI_PWR_BIT   = 5;
   localparam logic [7:0]  OPT_IMPL_MASK     = 8'h3F;
   localparam logic [7:0]  OPT_RESET         = 8'h00;

   // Status register field positions
   localparam int unsigned STAT_USED_BIT = 0;
   localparam int unsigned STAT_ROM_BIT  = 1;

   // Crystal clock cycle counts
   localparam logic [12:0] STOP_SHORT_CYCLES = 13'h0020;
   localparam logic [12:0] STOP_LONG_CYCLES  = 13'h1000;
   // 2^18 - 2^4 and 2^13 - 2^4
   localparam logic [17:0] WDOG_LONG_CYCLES  = 18'h3FFF0;
   localparam logic [17:0] WDOG_SHORT_CYCLES = 18'h01FF0;

   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   typedef struct packed {
      logic        dataPhase;
      logic        dataWrite;
      logic        dataIsOpt;
      logic        writeUsed;
      logic        romVariant;
      logic        strapTaken;
      logic [7:0]  optBits;
      logic [31:0] hrdata;
      logic        hreadyout;
   } wso_state_t;

   typedef struct packed {
      logic        lviPowerOff;
      logic        lviResetOut;
      logic        wdogOn;
      logic [17:0] wdogTimeout;
      logic [12:0] stopDelay;
      logic        stopExec;
      logic        stopIllegal;
   } wso_dec_state_t;

endpackage

`default_nettype wire

// file: rtl/wso_opt_if.sv
`default_nettype none

interface wso_opt_if;
   logic [7:0]  optBits;
   logic        lviResetReq;
   logic        stopReq;
   logic        lviPowerOff;
   logic        lviResetOut;
   logic        wdogOn;
   logic [17:0] wdogTimeout;
   logic [12:0] stopDelay;
   logic        stopExec;
   logic        stopIllegal;

   modport src (
      output optBits,
      output lviResetReq,
      output stopReq,
      input  lviPowerOff,
      input  lviResetOut,
      input  wdogOn,
      input  wdogTimeout,
      input  stopDelay,
      input  stopExec,
      input  stopIllegal
   );

   modport dst (
      input  optBits,
      input  lviResetReq,
      input  stopReq,
      output lviPowerOff,
      output lviResetOut,
      output wdogOn,
      output wdogTimeout,
      output stopDelay,
      output stopExec,
      output stopIllegal
   );
endinterface

`default_nettype wire

// file: rtl/wso_opt_decode.sv
`default_nettype none

module wso_opt_decode
   import wso_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstN,
   wso_opt_if.dst   opt
);

   wso_dec_state_t dec_reg;
   wso_dec_state_t dec_next;

   always_comb begin
      dec_next = dec_reg;
      dec_next.lviPowerOff = opt.optBits[OPT_LVI_PWR_BIT];
      dec_next.lviResetOut = opt.lviResetReq &
                             ~opt.optBits[OPT_LVI_RSTB_BIT];
      dec_next.wdogOn = ~opt.optBits[OPT_WDOG_OFF_BIT];
      if (opt.optBits[OPT_WDOG_LONG_BIT]) begin
         dec_next.wdogTimeout = WDOG_LONG_CYCLES;
      end else begin
         dec_next.wdogTimeout = WDOG_SHORT_CYCLES;
      end
      if (opt.optBits[OPT_SHORT_WK_BIT]) begin
         dec_next.stopDelay = STOP_SHORT_CYCLES;
      end else begin
         dec_next.stopDelay = STOP_LONG_CYCLES;
      end
      dec_next.stopExec    = opt.stopReq & opt.optBits[OPT_STOP_EN_BIT];
      dec_next.stopIllegal = opt.stopReq & ~opt.optBits[OPT_STOP_EN_BIT];
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         dec_reg <= '{lviPowerOff: 1'h0, lviResetOut: 1'h0, wdogOn: 1'h1,
                      wdogTimeout: WDOG_SHORT_CYCLES,
                      stopDelay: STOP_LONG_CYCLES,
                      stopExec: 1'h0, stopIllegal: 1'h0};
      end else begin
         dec_reg <= dec_next;
      end
   end

   assign opt.lviPowerOff = dec_reg.lviPowerOff;
   assign opt.lviResetOut = dec_reg.lviResetOut;
   assign opt.wdogOn      = dec_reg.wdogOn;
   assign opt.wdogTimeout = dec_reg.wdogTimeout;
   assign opt.stopDelay   = dec_reg.stopDelay;
   assign opt.stopExec    = dec_reg.stopExec;
   assign opt.stopIllegal = dec_reg.stopIllegal;

endmodule

`default_nettype wire

// file: rtl/wso_option_reg.sv
`default_nettype none

module wso_option_reg
   import wso_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic [31:0] hrdata,
   output var  logic        hresp,
   input  wire logic        romVariant,
   input  wire logic        lviResetReq,
   input  wire logic        stopReq,
   output var  logic        optionLocked,
   output var  logic        lviPowerOff,
   output var  logic        lviResetOut,
   output var  logic        wdogOn,
   output var  logic [17:0] wdogTimeout,
   output var  logic [12:0] stopDelay,
   output var  logic        stopExec,
   output var  logic        stopIllegal
);

   logic [1:0]  rstSync_reg;
   logic        rstN;
   wso_state_t  st_reg;
   wso_state_t  st_next;
   logic        addrTaken;
   logic        optWriteNow;
   logic [7:0]  optView;
   logic        usedView;
   wso_opt_if   optBus();

   // Asynchronous assert, synchronous release
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rstSync_reg <= 2'h0;
      end else begin
         rstSync_reg <= {rstSync_reg[0], 1'h1};
      end
   end
   assign rstN = rstSync_reg[1];

   assign addrTaken = hsel & hready & (htrans == HTRANS_NONSEQ);

   assign optWriteNow = st_reg.dataPhase & st_reg.dataWrite &
                        st_reg.dataIsOpt & ~st_reg.writeUsed &
                        ~st_reg.romVariant;

   // Forwarding so a read right behind the write sees the new value
   always_comb begin
      optView  = st_reg.optBits;
      usedView = st_reg.writeUsed;
      if (optWriteNow) begin
         optView = hwdata[7:0] & OPT_IMPL_MASK;
      end
      if (st_reg.dataPhase & st_reg.dataWrite & st_reg.dataIsOpt) begin
         usedView = 1'h1;
      end
   end

   always_comb begin
      st_next           = st_reg;
      st_next.hreadyout = 1'h1;
      // Strap taken once after release, never under reset
      if (!st_reg.strapTaken) begin
         st_next.romVariant = romVariant;
         st_next.strapTaken = 1'h1;
      end
      if (hready) begin
         st_next.dataPhase = addrTaken;
         st_next.dataWrite = addrTaken & hwrite;
         st_next.dataIsOpt = addrTaken & (haddr == OPT_REG_ADDR);
      end
      // Any write attempt to the address uses up the single write
      if (st_reg.dataPhase & st_reg.dataWrite & st_reg.dataIsOpt) begin
         st_next.writeUsed = 1'h1;
      end
      if (optWriteNow) begin
         st_next.optBits = optView;
      end
      // Read data prepared during the address phase
      st_next.hrdata = 32'h0000_0000;
      if (addrTaken && !hwrite) begin
         if (haddr == OPT_REG_ADDR) begin
            st_next.hrdata = {24'h00_0000, optView};
         end else if (haddr == STAT_REG_ADDR) begin
            st_next.hrdata[STAT_USED_BIT] = usedView;
            st_next.hrdata[STAT_ROM_BIT]  = st_reg.romVariant;
         end else begin
            st_next.hrdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         st_reg <= '{dataPhase: 1'h0, dataWrite: 1'h0, dataIsOpt: 1'h0,
                     writeUsed: 1'h0, romVariant: 1'h0, strapTaken: 1'h0,
                     optBits: OPT_RESET, hrdata: 32'h0000_0000,
                     hreadyout: 1'h1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign optBus.optBits     = st_reg.optBits;
   assign optBus.lviResetReq = lviResetReq;
   assign optBus.stopReq     = stopReq;

   wso_opt_decode u_decode (
      .clk_sys (clk_sys),
      .rstN    (rstN),
      .opt     (optBus.dst)
   );

   assign hreadyout    = st_reg.hreadyout;
   assign hrdata       = st_reg.hrdata;
   assign hresp        = HRESP_OKAY;
   assign optionLocked = st_reg.writeUsed;
   assign lviPowerOff  = optBus.lviPowerOff;
   assign lviResetOut  = optBus.lviResetOut;
   assign wdogOn       = optBus.wdogOn;
   assign wdogTimeout  = optBus.wdogTimeout;
   assign stopDelay    = optBus.stopDelay;
   assign stopExec     = optBus.stopExec;
   assign stopIllegal  = optBus.stopIllegal;

endmodule

`default_nettype wire

// file: bench/wso_option_reg_props.sv
`default_nettype none

module wso_option_reg_props
   import wso_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        lviResetReq,
   input wire logic        stopReq,
   input wire logic        optionLocked,
   input wire logic        lviPowerOff,
   input wire logic        lviResetOut,
   input wire logic        wdogOn,
   input wire logic [17:0] wdogTimeout,
   input wire logic [12:0] stopDelay,
   input wire logic        stopExec,
   input wire logic        stopIllegal
);
   logic take;
   logic wrOpt;
   assign take = hsel && hready && htrans == HTRANS_NONSEQ;
   assign wrOpt = take && hwrite && haddr == OPT_REG_ADDR;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // Write-to-read skew excluded: decode lags the stored bits
   sequence s_rdOpt;
      take && !hwrite && haddr == OPT_REG_ADDR && !$past(wrOpt);
   endsequence
   sequence s_rd;
      take && !hwrite;
   endsequence

   property p_okay;
      hreadyout && hresp == HRESP_OKAY;
   endproperty
   a_okay: assert property (p_okay)
      else $error("bus answer not ready or not okay");
   property p_lockHold;
      optionLocked |=> optionLocked;
   endproperty
   a_lockHold: assert property (p_lockHold)
      else $error("single write re-armed without reset");
   property p_lockCause;
      $rose(optionLocked) |-> $past(wrOpt, 2);
   endproperty
   a_lockCause: assert property (p_lockCause)
      else $error("lock set without option write");
   property p_rdHigh;
      s_rd |=> hrdata[31:8] == 24'h0;
   endproperty
   a_rdHigh: assert property (p_rdHigh)
      else $error("read data upper bits not zero");
   property p_decode;
      s_rdOpt |=> hrdata[OPT_WDOG_OFF_BIT] == !wdogOn
         && hrdata[OPT_LVI_PWR_BIT] == lviPowerOff
         && hrdata[OPT_SHORT_WK_BIT] == (stopDelay == STOP_SHORT_CYCLES)
         && hrdata[OPT_WDOG_LONG_BIT] == (wdogTimeout == WDOG_LONG_CYCLES);
   endproperty
   a_decode: assert property (p_decode)
      else $error("decoded controls disagree with option bits");
   property p_lvi;
      lviResetOut |-> $past(lviResetReq);
   endproperty
   a_lvi: assert property (p_lvi)
      else $error("monitor reset out without request");
   property p_stopOne;
      stopReq |=> stopExec != stopIllegal;
   endproperty
   a_stopOne: assert property (p_stopOne)
      else $error("stop request not resolved to one outcome");
   property p_resetVal;
      $rose(nrst) |-> !optionLocked && wdogOn && !lviPowerOff
         && stopDelay == STOP_LONG_CYCLES;
   endproperty
   a_resetVal: assert property (p_resetVal)
      else $error("outputs not at reset values");
endmodule

bind wso_option_reg wso_option_reg_props i_wso_option_reg_props (
   .clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
   .hrdata, .hresp, .lviResetReq, .stopReq, .optionLocked, .lviPowerOff,
   .lviResetOut, .wdogOn, .wdogTimeout, .stopDelay, .stopExec, .stopIllegal
);

`default_nettype wire

// file: bench/wso_option_reg_tb.sv
`default_nettype none

module wso_option_reg_tb
   import wso_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, nrst, hsel, hwrite, romVariant, lviResetReq;
   logic        stopReq, hreadyout, hresp, optionLocked, lviPowerOff;
   logic        lviResetOut, wdogOn, stopExec, stopIllegal;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [17:0] wdogTimeout;
   logic [12:0] stopDelay;
   int          n_errors, comparisons;

   wso_option_reg i_wso_option_reg (
      .clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .romVariant,
      .lviResetReq, .stopReq, .optionLocked, .lviPowerOff, .lviResetOut,
      .wdogOn, .wdogTimeout, .stopDelay, .stopExec, .stopIllegal
   );

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Entered just after a rising edge; zero wait states not assumed
   task automatic bus(input logic wr, input logic [31:0] a, d);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask

   task automatic do_reset(input logic rom);
      nrst <= 1'h0;
      romVariant <= rom;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'h1;
      repeat (4) @(posedge clk_sys);
   endtask

   task automatic pulse;
      stopReq <= 1'h1;
      lviResetReq <= 1'h1;
      @(posedge clk_sys);
      stopReq <= 1'h0;
      lviResetReq <= 1'h0;
      @(posedge clk_sys);
   endtask

   task automatic t_reset_values;
      bus(1'h0, OPT_REG_ADDR, 32'h0);
      chk(q, 32'h0);
      chk({wdogOn, stopDelay, wdogTimeout},
          {1'h1, STOP_LONG_CYCLES, WDOG_SHORT_CYCLES});
   endtask

   task automatic t_first_write;
      bus(1'h1, OPT_REG_ADDR, 32'hED);
      bus(1'h0, OPT_REG_ADDR, 32'h0);
      chk(q, 32'h2D);
      chk({wdogOn, stopDelay, wdogTimeout},
          {1'h0, STOP_SHORT_CYCLES, WDOG_LONG_CYCLES});
      chk({optionLocked, lviPowerOff}, 2'h3);
      bus(1'h1, OPT_REG_ADDR, 32'h12);
      bus(1'h0, OPT_REG_ADDR, 32'h0);
      chk(q, 32'h2D);
      bus(1'h0, STAT_REG_ADDR, 32'h0);
      chk(q, 32'h1);
      pulse();
      chk({stopExec, stopIllegal, lviResetOut}, 3'h3);
   endtask

   task automatic t_rearm;
      do_reset(1'h0);
      bus(1'h1, OPT_REG_ADDR, 32'h12);
      bus(1'h0, OPT_REG_ADDR, 32'h0);
      chk(q, 32'h12);
      pulse();
      chk({stopExec, stopIllegal, lviResetOut}, 3'h4);
      chk({wdogOn, stopDelay, wdogTimeout},
          {1'h1, STOP_LONG_CYCLES, WDOG_SHORT_CYCLES});
      chk({31'h0, lviPowerOff}, 32'h0);
   endtask

   // Armed register, so a stray decode would consume the write
   task automatic t_unmapped;
      do_reset(1'h0);
      bus(1'h1, 32'h100, 32'hFF);
      bus(1'h1, STAT_REG_ADDR, 32'hFF);
      bus(1'h0, 32'h100, 32'h0);
      chk(q, 32'h0);
      bus(1'h0, STAT_REG_ADDR, 32'h0);
      chk(q, 32'h0);
      bus(1'h0, OPT_REG_ADDR, 32'h0);
      chk(q, 32'h0);
      bus(1'h1, OPT_REG_ADDR, 32'h21);
      bus(1'h0, OPT_REG_ADDR, 32'h0);
      chk(q, 32'h21);
   endtask

   task automatic t_rom;
      do_reset(1'h1);
      bus(1'h1, OPT_REG_ADDR, 32'h3F);
      bus(1'h0, OPT_REG_ADDR, 32'h0);
      chk(q, 32'h0);
      bus(1'h0, STAT_REG_ADDR, 32'h0);
      chk(q, 32'h3);
   endtask

   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (3000) @(posedge clk_sys);
      n_errors++;
      close_out();
   end

   initial begin
      {nrst, hsel, hwrite, romVariant, lviResetReq, stopReq} = 6'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      @(posedge clk_sys);
      do_reset(1'h0);
      t_reset_values();
      t_first_write();
      t_rearm();
      t_unmapped();
      t_rom();
      close_out();
   end
endmodule

`default_nettype wire
